// >>> rtl/gpio_pkg.sv
// Package with register map, field encodings and timing constants of the port block.
package gpio_pkg;

  // Register addresses on the register file.
  localparam logic [7:0] ADDR_KEY_IN_DATA = 8'he0;
  localparam logic [7:0] ADDR_KEY_OUT_DATA = 8'he1;
  localparam logic [7:0] ADDR_THIRD_DATA = 8'he2;
  localparam logic [7:0] ADDR_IR_DATA = 8'he3;
  localparam logic [7:0] ADDR_KEY_IN_PUR = 8'he7;
  localparam logic [7:0] ADDR_KEY_IN_CTRL_H = 8'he8;
  localparam logic [7:0] ADDR_KEY_IN_CTRL_L = 8'he9;
  localparam logic [7:0] ADDR_KEY_OUT_CTRL_H = 8'hea;
  localparam logic [7:0] ADDR_KEY_OUT_CTRL_L = 8'heb;
  localparam logic [7:0] ADDR_THIRD_CTRL_H = 8'hec;
  localparam logic [7:0] ADDR_THIRD_CTRL_L = 8'hed;
  localparam logic [7:0] ADDR_THIRD_PUR = 8'hee;
  localparam logic [7:0] ADDR_IR_CTRL = 8'hef;
  localparam logic [7:0] ADDR_KEY_IN_IRQ_EN = 8'hf1;
  localparam logic [7:0] ADDR_KEY_IN_IRQ_PEND = 8'hf2;
  localparam logic [7:0] ADDR_THIRD_IRQ_EN = 8'hf3;
  localparam logic [7:0] ADDR_THIRD_IRQ_PEND = 8'hf4;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IR_BITS = 2'h0;

  // Key-input port two-bit pin modes.
  localparam logic [1:0] KIN_FALL = 2'h0;
  localparam logic [1:0] KIN_BOTH = 2'h1;
  localparam logic [1:0] KIN_PUSH = 2'h2;
  localparam logic [1:0] KIN_RISE = 2'h3;

  // Key-output port two-bit pin modes.
  localparam logic [1:0] KOUT_INPUT = 2'h0;
  localparam logic [1:0] KOUT_OPEN = 2'h1;
  localparam logic [1:0] KOUT_PUSH = 2'h2;
  localparam logic [1:0] KOUT_INPUT_PU = 2'h3;

  // Third port two-bit pin modes.
  localparam logic [1:0] THIRD_IN_FALL = 2'h0;
  localparam logic [1:0] THIRD_IN_RISE = 2'h1;
  localparam logic [1:0] THIRD_PUSH = 2'h2;
  localparam logic [1:0] THIRD_OPEN = 2'h3;

  // Infrared port three-bit pin modes; pin 0 uses bits 2:0, pin 1 bits 5:3.
  localparam int IR_MODE_W = 3;
  localparam logic [2:0] IR_INPUT = 3'h0;
  localparam logic [2:0] IR_INPUT_PU = 3'h1;
  localparam logic [2:0] IR_PUSH = 3'h2;
  localparam logic [2:0] IR_OPEN = 3'h3;
  localparam logic [2:0] IR_ALT = 3'h4;

  // Field positions.
  localparam int IR_CARRIER_BIT = 7;
  localparam int IR_PIN0_LSB = 0;
  localparam int IR_PIN1_LSB = 3;

  // Noise filter time and its cycle count at the reference clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> rtl/gpio_ports.sv
// Four-port general-purpose I/O block with pin filters, pending flags and pull-up control.
`timescale 1ns/1ns
module gpio_ports
  import gpio_pkg::*;
#(
  parameter int FILTER_COUNT = FILTER_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register file access.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Key-input port pins.
  input wire logic [7:0] key_input_port_in,
  output logic [7:0] key_input_port_out,
  output logic [7:0] key_input_port_oe,
  output logic [7:0] key_input_port_pullup,
  // Key-output port pins.
  input wire logic [7:0] key_output_port_in,
  output logic [7:0] key_output_port_out,
  output logic [7:0] key_output_port_oe,
  output logic [7:0] key_output_port_pullup,
  // Third port pins.
  input wire logic [7:0] third_port_in,
  output logic [7:0] third_port_out,
  output logic [7:0] third_port_oe,
  output logic [7:0] third_port_pullup,
  // Infrared port pins.
  input wire logic [1:0] ir_port_in,
  output logic [1:0] ir_port_out,
  output logic [1:0] ir_port_oe,
  output logic [1:0] ir_port_pullup,
  // Timer and carrier links.
  input wire logic timer_a_pwm_src,
  input wire logic remote_carrier_src,
  output logic timer_a_clock_in,
  output logic timer_a_capture_in,
  output logic timer_b_capture_in,
  // Interrupt requests.
  output logic key_input_irq,
  output logic third_port_irq
);

  // Two-bit mode field of pin i in a sixteen-bit control pair.
  function automatic logic [1:0] mode_of(input logic [15:0] ctrl, input int i);
    mode_of = ctrl[2*i +: 2];
  endfunction

  // Edge event of a filtered level given rise and fall enables.
  function automatic logic edge_hit(input logic now, input logic was, input logic on_rise,
                                    input logic on_fall);
    edge_hit = (on_rise & now & ~was) | (on_fall & ~now & was);
  endfunction

  // Pending update: write of zero clears, new event wins over the clear.
  function automatic logic [7:0] pend_next(input logic [7:0] pend, input logic wr,
                                           input logic [7:0] wdata, input logic [7:0] set);
    pend_next = (pend & (wr ? wdata : 8'hff)) | set;
  endfunction

  // Software registers.
  logic [7:0] kin_data_q, kout_data_q, third_data_q;
  logic [1:0] ir_data_q;
  logic carrier_on_q;
  logic [7:0] kin_pur_q, third_pur_q;
  logic [15:0] kin_ctrl_q, kout_ctrl_q, third_ctrl_q;
  logic [5:0] ir_ctrl_q;
  logic [7:0] kin_en_q, kin_pend_q, third_en_q, third_pend_q;
  logic [7:0] kin_prev_q, third_prev_q;
  logic [7:0] rdata_q;

  // Output flip-flops.
  logic [7:0] kin_out_q, kin_oe_q, kin_pu_q;
  logic [7:0] kout_out_q, kout_oe_q, kout_pu_q;
  logic [7:0] third_out_q, third_oe_q, third_pu_q;
  logic [1:0] ir_out_q, ir_oe_q, ir_pu_q;
  logic t_a_clk_q, t_a_cap_q, t_b_cap_q;
  logic kin_irq_q, third_irq_q;

  // Filtered pin levels.
  logic [7:0] kin_clean, third_clean;

  noise_filter #(.WIDTH(8), .COUNT(FILTER_COUNT)) kin_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(key_input_port_in),
    .clean(kin_clean)
  );

  noise_filter #(.WIDTH(8), .COUNT(FILTER_COUNT)) third_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(third_port_in),
    .clean(third_clean)
  );

  // Address decode of write strobes.
  // data, pull-up, control and interrupt register decode
  wire wr_kin_data = reg_wr && reg_addr == ADDR_KEY_IN_DATA;
  wire wr_kout_data = reg_wr && reg_addr == ADDR_KEY_OUT_DATA;
  wire wr_third_data = reg_wr && reg_addr == ADDR_THIRD_DATA;
  wire wr_ir_data = reg_wr && reg_addr == ADDR_IR_DATA;
  wire wr_kin_pur = reg_wr && reg_addr == ADDR_KEY_IN_PUR;
  wire wr_third_pur = reg_wr && reg_addr == ADDR_THIRD_PUR;
  wire wr_kin_ch = reg_wr && reg_addr == ADDR_KEY_IN_CTRL_H;
  wire wr_kin_cl = reg_wr && reg_addr == ADDR_KEY_IN_CTRL_L;
  wire wr_kout_ch = reg_wr && reg_addr == ADDR_KEY_OUT_CTRL_H;
  wire wr_kout_cl = reg_wr && reg_addr == ADDR_KEY_OUT_CTRL_L;
  wire wr_third_ch = reg_wr && reg_addr == ADDR_THIRD_CTRL_H;
  wire wr_third_cl = reg_wr && reg_addr == ADDR_THIRD_CTRL_L;
  wire wr_ir_ctrl = reg_wr && reg_addr == ADDR_IR_CTRL;
  wire wr_kin_en = reg_wr && reg_addr == ADDR_KEY_IN_IRQ_EN;
  wire wr_kin_pend = reg_wr && reg_addr == ADDR_KEY_IN_IRQ_PEND;
  wire wr_third_en = reg_wr && reg_addr == ADDR_THIRD_IRQ_EN;
  wire wr_third_pend = reg_wr && reg_addr == ADDR_THIRD_IRQ_PEND;

  // Infrared pin mode fields.
  wire [2:0] ir_mode0 = ir_ctrl_q[IR_PIN0_LSB +: IR_MODE_W];
  wire [2:0] ir_mode1 = ir_ctrl_q[IR_PIN1_LSB +: IR_MODE_W];

  // Per-pin drive and pull-up for the three byte-wide ports, edge decode for the key-input and third ports.
  logic [7:0] kin_out_d, kin_oe_d, kin_pu_d, kin_set;
  logic [7:0] kout_out_d, kout_oe_d, kout_pu_d;
  logic [7:0] third_out_d, third_oe_d, third_pu_d, third_set;
  always_comb begin
    logic [1:0] m;
    m = 2'h0;
    for (int i = 0; i < 8; i++) begin
      m = mode_of(kin_ctrl_q, i);
      kin_oe_d[i] = (m == KIN_PUSH);
      kin_out_d[i] = (m == KIN_PUSH) & kin_data_q[i];
      kin_pu_d[i] = kin_pur_q[i] & (m != KIN_PUSH);
      kin_set[i] = kin_en_q[i] & (m != KIN_PUSH) &
                   edge_hit(kin_clean[i], kin_prev_q[i], m == KIN_RISE || m == KIN_BOTH,
                            m == KIN_FALL || m == KIN_BOTH);
      m = mode_of(kout_ctrl_q, i);
      kout_oe_d[i] = (m == KOUT_PUSH) | ((m == KOUT_OPEN) & ~kout_data_q[i]);
      kout_out_d[i] = (m == KOUT_PUSH) & kout_data_q[i];
      kout_pu_d[i] = (m == KOUT_INPUT_PU);
      m = mode_of(third_ctrl_q, i);
      third_oe_d[i] = (m == THIRD_PUSH) | ((m == THIRD_OPEN) & ~third_data_q[i]);
      third_out_d[i] = (m == THIRD_PUSH) & third_data_q[i];
      third_pu_d[i] = third_pur_q[i] & (m == THIRD_IN_FALL || m == THIRD_IN_RISE);
      third_set[i] = third_en_q[i] &
                     edge_hit(third_clean[i], third_prev_q[i], m == THIRD_IN_RISE,
                              m == THIRD_IN_FALL);
    end
  end

  // Infrared port drive: alternate function, push-pull, open-drain or input.
  logic [1:0] ir_out_d, ir_oe_d, ir_pu_d;
  logic [1:0] ir_alt_val;
  logic [2:0] ir_mode [2];
  always_comb begin
    ir_mode[0] = ir_mode0;
    ir_mode[1] = ir_mode1;
    ir_alt_val[0] = timer_a_pwm_src;
    ir_alt_val[1] = remote_carrier_src & carrier_on_q;
    for (int i = 0; i < 2; i++) begin
      case (ir_mode[i])
        IR_PUSH: begin
          ir_oe_d[i] = 1'b1;
          ir_out_d[i] = ir_data_q[i];
        end
        IR_OPEN: begin
          ir_oe_d[i] = ~ir_data_q[i];
          ir_out_d[i] = 1'b0;
        end
        IR_ALT: begin
          ir_oe_d[i] = 1'b1;
          ir_out_d[i] = ir_alt_val[i];
        end
        default: begin
          ir_oe_d[i] = 1'b0;
          ir_out_d[i] = 1'b0;
        end
      endcase
      ir_pu_d[i] = (ir_mode[i] == IR_INPUT_PU);
    end
  end

  // Pending next values.
  // pending polling and clear
  wire [7:0] kin_pend_d = pend_next(kin_pend_q, wr_kin_pend, reg_wdata, kin_set);
  wire [7:0] third_pend_d = pend_next(third_pend_q, wr_third_pend, reg_wdata, third_set);

  // Read selection; data registers show pin levels, unmapped addresses read zero.
  logic [7:0] rdata_d;
  always_comb begin
    case (reg_addr)
      ADDR_KEY_IN_DATA: rdata_d = key_input_port_in;
      ADDR_KEY_OUT_DATA: rdata_d = key_output_port_in;
      ADDR_THIRD_DATA: rdata_d = third_port_in;
      ADDR_IR_DATA: rdata_d = {carrier_on_q, 5'h00, ir_port_in};
      ADDR_KEY_IN_PUR: rdata_d = kin_pur_q;
      ADDR_THIRD_PUR: rdata_d = third_pur_q;
      ADDR_KEY_IN_CTRL_H: rdata_d = kin_ctrl_q[15:8];
      ADDR_KEY_IN_CTRL_L: rdata_d = kin_ctrl_q[7:0];
      ADDR_KEY_OUT_CTRL_H: rdata_d = kout_ctrl_q[15:8];
      ADDR_KEY_OUT_CTRL_L: rdata_d = kout_ctrl_q[7:0];
      ADDR_THIRD_CTRL_H: rdata_d = third_ctrl_q[15:8];
      ADDR_THIRD_CTRL_L: rdata_d = third_ctrl_q[7:0];
      ADDR_IR_CTRL: rdata_d = {2'h0, ir_ctrl_q};
      ADDR_KEY_IN_IRQ_EN: rdata_d = kin_en_q;
      ADDR_KEY_IN_IRQ_PEND: rdata_d = kin_pend_q;
      ADDR_THIRD_IRQ_EN: rdata_d = third_en_q;
      ADDR_THIRD_IRQ_PEND: rdata_d = third_pend_q;
      default: rdata_d = RST_BYTE;
    endcase
  end

  // Data latches and pull-up enables.
  // data, carrier and pull-up register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kin_data_q <= RST_BYTE;
      kout_data_q <= RST_BYTE;
      third_data_q <= RST_BYTE;
      ir_data_q <= RST_IR_BITS;
      carrier_on_q <= 1'b0;
      kin_pur_q <= RST_BYTE;
      third_pur_q <= RST_BYTE;
    end else begin
      if (wr_kin_data) kin_data_q <= reg_wdata;
      if (wr_kout_data) kout_data_q <= reg_wdata;
      if (wr_third_data) third_data_q <= reg_wdata;
      if (wr_ir_data) ir_data_q <= reg_wdata[1:0];
      if (wr_ir_data) carrier_on_q <= reg_wdata[IR_CARRIER_BIT];
      if (wr_kin_pur) kin_pur_q <= reg_wdata;
      if (wr_third_pur) third_pur_q <= reg_wdata;
    end
  end

  // Control registers; reset makes every key-output pin a CMOS input.
  // reset to input
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kin_ctrl_q <= {RST_BYTE, RST_BYTE};
      kout_ctrl_q <= {RST_BYTE, RST_BYTE};
      third_ctrl_q <= {RST_BYTE, RST_BYTE};
      ir_ctrl_q <= {IR_INPUT, IR_INPUT};
    end else begin
      if (wr_kin_ch) kin_ctrl_q[15:8] <= reg_wdata;
      if (wr_kin_cl) kin_ctrl_q[7:0] <= reg_wdata;
      if (wr_kout_ch) kout_ctrl_q[15:8] <= reg_wdata;
      if (wr_kout_cl) kout_ctrl_q[7:0] <= reg_wdata;
      if (wr_third_ch) third_ctrl_q[15:8] <= reg_wdata;
      if (wr_third_cl) third_ctrl_q[7:0] <= reg_wdata;
      if (wr_ir_ctrl) ir_ctrl_q <= reg_wdata[5:0];
    end
  end

  // Interrupt enables, pending flags and edge history.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kin_en_q <= RST_BYTE;
      third_en_q <= RST_BYTE;
      kin_pend_q <= RST_BYTE;
      third_pend_q <= RST_BYTE;
      kin_prev_q <= RST_BYTE;
      third_prev_q <= RST_BYTE;
    end else begin
      if (wr_kin_en) kin_en_q <= reg_wdata;
      if (wr_third_en) third_en_q <= reg_wdata;
      kin_pend_q <= kin_pend_d;
      third_pend_q <= third_pend_d;
      kin_prev_q <= kin_clean;
      third_prev_q <= third_clean;
    end
  end

  // Registered pin drive, timer feeds, requests and read data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {kin_out_q, kin_oe_q, kin_pu_q} <= '0;
      {kout_out_q, kout_oe_q, kout_pu_q} <= '0;
      {third_out_q, third_oe_q, third_pu_q} <= '0;
      {ir_out_q, ir_oe_q, ir_pu_q} <= '0;
      {t_a_clk_q, t_a_cap_q, t_b_cap_q} <= '0;
      {kin_irq_q, third_irq_q} <= '0;
      rdata_q <= RST_BYTE;
    end else begin
      {kin_out_q, kin_oe_q, kin_pu_q} <= {kin_out_d, kin_oe_d, kin_pu_d};
      {kout_out_q, kout_oe_q, kout_pu_q} <= {kout_out_d, kout_oe_d, kout_pu_d};
      {third_out_q, third_oe_q, third_pu_q} <= {third_out_d, third_oe_d, third_pu_d};
      {ir_out_q, ir_oe_q, ir_pu_q} <= {ir_out_d, ir_oe_d, ir_pu_d};
      t_a_clk_q <= ir_port_in[0];
      t_a_cap_q <= ir_port_in[0];
      t_b_cap_q <= ir_port_in[1];
      kin_irq_q <= |kin_pend_d;
      third_irq_q <= |third_pend_d;
      if (reg_rd) rdata_q <= rdata_d;
    end
  end

  // Output assignments straight from flip-flops.
  assign reg_rdata = rdata_q;
  assign key_input_port_out = kin_out_q;
  assign key_input_port_oe = kin_oe_q;
  assign key_input_port_pullup = kin_pu_q;
  assign key_output_port_out = kout_out_q;
  assign key_output_port_oe = kout_oe_q;
  assign key_output_port_pullup = kout_pu_q;
  assign third_port_out = third_out_q;
  assign third_port_oe = third_oe_q;
  assign third_port_pullup = third_pu_q;
  assign ir_port_out = ir_out_q;
  assign ir_port_oe = ir_oe_q;
  assign ir_port_pullup = ir_pu_q;
  assign timer_a_clock_in = t_a_clk_q;
  assign timer_a_capture_in = t_a_cap_q;
  assign timer_b_capture_in = t_b_cap_q;
  assign key_input_irq = kin_irq_q;
  assign third_port_irq = third_irq_q;

endmodule

// >>> rtl/noise_filter.sv
// Per-bit glitch filter that passes a level only after it has been stable long enough.
`timescale 1ns/1ns
module noise_filter
  import gpio_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int COUNT = FILTER_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Raw and filtered levels.
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_q [WIDTH];
  logic [WIDTH-1:0] clean_q;

  // A differing level must persist for COUNT cycles before it is taken.
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < WIDTH; i++) begin
      if (rst) begin
        cnt_q[i] <= '0;
        clean_q[i] <= raw[i]; // Track the pin so no false edge follows reset.
      end else if (raw[i] == clean_q[i]) begin
        cnt_q[i] <= '0;
      end else if (cnt_q[i] == LAST) begin
        cnt_q[i] <= '0;
        clean_q[i] <= raw[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end

  assign clean = clean_q;

endmodule

// >>> verification/gpio_ports_assertions.sv
// Checker of the port block's register and pin behaviour, bound to its top module.
`timescale 1ns/1ns
module gpio_ports_assertions
  import gpio_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register file access.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pin controls and timer feeds.
  input wire logic [7:0] key_output_port_oe,
  input wire logic [7:0] key_output_port_pullup,
  input wire logic [1:0] ir_port_in,
  input wire logic [1:0] ir_port_oe,
  input wire logic [1:0] ir_port_pullup,
  input wire logic timer_a_clock_in,
  input wire logic timer_b_capture_in,
  // Interrupt requests.
  input wire logic key_input_irq,
  input wire logic third_port_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Key-output pins are plain inputs without pull-ups right after reset.
  property p_rst_out;
    $past(rst) |-> key_output_port_oe == 8'h00 && key_output_port_pullup == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  // Read data only moves on a read.
  property p_rdata_hold;
    !$past(reg_rd) && !$past(rst) |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // A hole in the map reads as zero.
  property p_unmapped;
    reg_rd && reg_addr == 8'he4 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // The two-bit port data byte keeps bits 6 to 2 clear.
  property p_ir_read;
    reg_rd && reg_addr == ADDR_IR_DATA |=> reg_rdata[6:2] == 5'h00;
  endproperty
  a_ir_read: assert property (p_ir_read) else $error("ir data spare bits set");
  // Timer feeds are the pin levels one cycle late.
  property p_timer;
    !$past(rst) |-> timer_a_clock_in == $past(ir_port_in[0])
      && timer_b_capture_in == $past(ir_port_in[1]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer feed wrong");
  // A driven key-output pin never has its pull-up on.
  property p_kout_pu;
    (key_output_port_pullup & key_output_port_oe) == 8'h00;
  endproperty
  a_kout_pu: assert property (p_kout_pu) else $error("pull-up on output pin");
  // Two-bit port pull-ups only in input mode.
  property p_ir_pu;
    (ir_port_pullup & ir_port_oe) == 2'h0;
  endproperty
  a_ir_pu: assert property (p_ir_pu) else $error("ir pull-up on output pin");
  // The key-input request drops only on a pending write.
  property p_kin_clear;
    $fell(key_input_irq) |-> $past(reg_wr) && $past(reg_addr) == ADDR_KEY_IN_IRQ_PEND;
  endproperty
  a_kin_clear: assert property (p_kin_clear) else $error("key irq fell alone");
  // The third-port request drops only on a pending write.
  property p_thd_clear;
    $fell(third_port_irq) |-> $past(reg_wr) && $past(reg_addr) == ADDR_THIRD_IRQ_PEND;
  endproperty
  a_thd_clear: assert property (p_thd_clear) else $error("third irq fell alone");
  // Writing ones to pending keeps the request.
  property p_pend_one;
    reg_wr && reg_addr == ADDR_KEY_IN_IRQ_PEND && reg_wdata == 8'hff && key_input_irq
      |=> key_input_irq;
  endproperty
  a_pend_one: assert property (p_pend_one) else $error("ones cleared pending");
endmodule

bind gpio_ports gpio_ports_assertions chk_i (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .key_output_port_oe(key_output_port_oe),
  .key_output_port_pullup(key_output_port_pullup), .ir_port_in(ir_port_in),
  .ir_port_oe(ir_port_oe), .ir_port_pullup(ir_port_pullup),
  .timer_a_clock_in(timer_a_clock_in), .timer_b_capture_in(timer_b_capture_in),
  .key_input_irq(key_input_irq), .third_port_irq(third_port_irq));

// >>> verification/pin_model.sv
// Board model of a port: device drive, board drive, pull-ups and floating lines.
`timescale 1ns/1ns
module pin_model #(
  parameter int W = 8
) (
  // Clock.
  input wire logic ref_clk,
  // Device and board drive.
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  // Resolved pin level.
  output logic [W-1:0] level
);
  logic [W-1:0] last_q = '0;
  // Device wins, then board, then pull-up; a floating line toggles every cycle.
  assign level = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull_en | ~last_q));
  // Remember the level so floating lines show a changing pattern.
  always_ff @(posedge ref_clk) begin
    last_q <= level;
  end
endmodule

// >>> verification/tb.sv
// Self-checking testbench of the four-port pin block.
`timescale 1ns/1ns
module tb;
  import gpio_pkg::*;
  localparam int FC = 2;
  logic ref_clk, rst, reg_wr, reg_rd, pwm_src, car_src, tac, tacap, tbcap, kirq, tirq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, kin_val, thd_val, kout_val;
  logic [7:0] kin_lvl, kin_out, kin_oe, kin_pu, kout_lvl, kout_out, kout_oe, kout_pu;
  logic [7:0] thd_lvl, thd_out, thd_oe, thd_pu;
  logic [1:0] ir_lvl, ir_out, ir_oe, ir_pu, ir_en, ir_val;
  int errors, num_checks, cycles;

  gpio_ports #(.FILTER_COUNT(FC)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .key_input_port_in(kin_lvl), .key_input_port_out(kin_out), .key_input_port_oe(kin_oe),
    .key_input_port_pullup(kin_pu), .key_output_port_in(kout_lvl),
    .key_output_port_out(kout_out), .key_output_port_oe(kout_oe),
    .key_output_port_pullup(kout_pu), .third_port_in(thd_lvl), .third_port_out(thd_out),
    .third_port_oe(thd_oe), .third_port_pullup(thd_pu), .ir_port_in(ir_lvl),
    .ir_port_out(ir_out), .ir_port_oe(ir_oe), .ir_port_pullup(ir_pu),
    .timer_a_pwm_src(pwm_src), .remote_carrier_src(car_src), .timer_a_clock_in(tac),
    .timer_a_capture_in(tacap), .timer_b_capture_in(tbcap), .key_input_irq(kirq),
    .third_port_irq(tirq));
  pin_model #(.W(8)) kin_pins (.ref_clk(ref_clk), .out(kin_out), .oe(kin_oe),
    .pull_en(kin_pu), .ext_en(8'hff), .ext_val(kin_val), .level(kin_lvl));
  pin_model #(.W(8)) kout_pins (.ref_clk(ref_clk), .out(kout_out), .oe(kout_oe),
    .pull_en(kout_pu), .ext_en(8'hff), .ext_val(kout_val), .level(kout_lvl));
  pin_model #(.W(8)) thd_pins (.ref_clk(ref_clk), .out(thd_out), .oe(thd_oe),
    .pull_en(thd_pu), .ext_en(8'hff), .ext_val(thd_val), .level(thd_lvl));
  pin_model #(.W(2)) ir_pins (.ref_clk(ref_clk), .out(ir_out), .oe(ir_oe),
    .pull_en(ir_pu), .ext_en(ir_en), .ext_val(ir_val), .level(ir_lvl));

  // Compare and count.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One register write, strobe held for one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // One register read, compared half a cycle after the taking edge.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  // Pin outputs follow a write two edges later.
  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask
  // Move a pin, watch the request, read and clear pending.
  task automatic pin_irq(input logic port, input logic [7:0] v, input logic exp,
                         input logic [7:0] pend);
    logic seen;
    seen = 1'b0;
    if (port) thd_val = v;
    else kin_val = v;
    repeat (FC + 6) begin
      @(negedge ref_clk);
      if ((port ? tirq : kirq) === 1'b1) seen = 1'b1;
    end
    chk({7'h00, seen}, {7'h00, exp});
    rdchk(port ? ADDR_THIRD_IRQ_PEND : ADDR_KEY_IN_IRQ_PEND, pend);
    wr(port ? ADDR_THIRD_IRQ_PEND : ADDR_KEY_IN_IRQ_PEND, 8'hff);
    chk({7'h00, port ? tirq : kirq}, {7'h00, exp});
    wr(port ? ADDR_THIRD_IRQ_PEND : ADDR_KEY_IN_IRQ_PEND, 8'h00);
    chk({7'h00, port ? tirq : kirq}, 8'h00);
  endtask

  // Reset state of pins and registers.
  task automatic t_reset;
    chk(kout_oe, 8'h00);
    chk(kout_pu, 8'h00);
    rdchk(ADDR_KEY_IN_PUR, 8'h00);
    rdchk(ADDR_KEY_OUT_CTRL_L, 8'h00);
    $display("test reset done");
  endtask
  // Key-output port modes and data access.
  task automatic t_kout;
    wr(ADDR_KEY_OUT_CTRL_H, 8'haa);
    wr(ADDR_KEY_OUT_CTRL_L, 8'haa);
    wr(ADDR_KEY_OUT_DATA, 8'h5a);
    settle;
    chk(kout_oe, 8'hff);
    chk(kout_out, 8'h5a);
    settle;
    rdchk(ADDR_KEY_OUT_DATA, 8'h5a);
    wr(ADDR_KEY_OUT_CTRL_H, 8'h55);
    wr(ADDR_KEY_OUT_CTRL_L, 8'h55);
    settle;
    chk(kout_oe, 8'ha5);
    chk(kout_out, 8'h00);
    settle;
    rdchk(ADDR_KEY_OUT_DATA, 8'h5a);
    kout_val = 8'h0f;
    rdchk(ADDR_KEY_OUT_DATA, 8'h0a);
    kout_val = 8'hff;
    wr(ADDR_KEY_OUT_CTRL_H, 8'hff);
    wr(ADDR_KEY_OUT_CTRL_L, 8'hff);
    settle;
    chk(kout_pu, 8'hff);
    chk(kout_oe, 8'h00);
    $display("test key output done");
  endtask
  // Pull-up enable registers and key-input output mode.
  task automatic t_pullup;
    wr(ADDR_KEY_IN_PUR, 8'hff);
    wr(ADDR_THIRD_PUR, 8'h3c);
    wr(ADDR_KEY_IN_CTRL_L, {6'h00, KIN_PUSH});
    wr(ADDR_KEY_IN_DATA, 8'h01);
    settle;
    rdchk(ADDR_KEY_IN_PUR, 8'hff);
    rdchk(ADDR_THIRD_PUR, 8'h3c);
    chk(kin_pu, 8'hfe);
    chk(thd_pu, 8'h3c);
    chk(kin_oe, 8'h01);
    chk(kin_out, 8'h01);
    wr(ADDR_KEY_IN_CTRL_L, {6'h00, KIN_FALL});
    wr(ADDR_KEY_IN_PUR, 8'h7e);
    settle;
    chk(kin_pu, 8'h7e);
    $display("test pull-up done");
  endtask
  // Key-input and third port interrupts.
  task automatic t_irq;
    wr(ADDR_KEY_IN_IRQ_EN, 8'h01);
    kin_val = 8'hfe;
    @(negedge ref_clk);
    pin_irq(1'b0, 8'hff, 1'b0, 8'h00);
    pin_irq(1'b0, 8'hfd, 1'b0, 8'h00);
    pin_irq(1'b0, 8'hfc, 1'b1, 8'h01);
    wr(ADDR_KEY_IN_CTRL_L, {6'h00, KIN_RISE});
    pin_irq(1'b0, 8'hff, 1'b1, 8'h01);
    pin_irq(1'b0, 8'hfe, 1'b0, 8'h00);
    wr(ADDR_KEY_IN_CTRL_L, {6'h00, KIN_BOTH});
    pin_irq(1'b0, 8'hff, 1'b1, 8'h01);
    pin_irq(1'b0, 8'hfe, 1'b1, 8'h01);
    wr(ADDR_THIRD_IRQ_EN, 8'h80);
    wr(ADDR_THIRD_CTRL_H, 8'h40);
    pin_irq(1'b1, 8'hff, 1'b1, 8'h80);
    pin_irq(1'b1, 8'h7f, 1'b0, 8'h00);
    wr(ADDR_THIRD_CTRL_L, {6'h00, THIRD_OPEN});
    wr(ADDR_THIRD_DATA, 8'h00);
    settle;
    chk(thd_oe, 8'h01);
    chk(thd_out, 8'h00);
    $display("test interrupt done");
  endtask
  // Two-bit port modes, carrier bit and map holes.
  task automatic t_ir;
    wr(ADDR_IR_CTRL, 8'h09);
    settle;
    chk({6'h00, ir_pu}, 8'h03);
    wr(ADDR_IR_CTRL, 8'h24);
    wr(ADDR_IR_DATA, 8'h80);
    pwm_src = 1'b1;
    car_src = 1'b1;
    settle;
    chk({6'h00, ir_out}, 8'h03);
    chk({6'h00, ir_pu}, 8'h00);
    pwm_src = 1'b0;
    settle;
    chk({6'h00, ir_out}, 8'h02);
    settle;
    rdchk(ADDR_IR_DATA, 8'h82);
    wr(ADDR_IR_DATA, 8'h00);
    settle;
    chk({6'h00, ir_out}, 8'h00);
    rdchk(ADDR_IR_CTRL, 8'h24);
    wr(8'he4, 8'hff);
    rdchk(8'he4, 8'h00);
    wr(ADDR_IR_CTRL, 8'h00);
    ir_en = 2'h3;
    ir_val = 2'h1;
    settle;
    chk({5'h00, tac, tacap, tbcap}, 8'h06);
    $display("test ir port done");
  endtask

  // Print the counts and the verdict, then stop.
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Cut a hang short.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      $display("MISMATCH t=%0t run too long", $time);
      conclude;
    end
  end
  // Main sequence.
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    kin_val = 8'hff;
    thd_val = 8'h7f;
    kout_val = 8'hff;
    ir_en = 2'h0;
    ir_val = 2'h0;
    pwm_src = 1'b0;
    car_src = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_kout;
    t_pullup;
    t_irq;
    t_ir;
    conclude;
  end
endmodule
